// ==== shared/aip_pkg.sv ====
package aip_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int AIP_CLK_HZ  = 40_000_000;
    localparam int AIP_STD_HZ  = 100_000;
    localparam int AIP_FAST_HZ = 400_000;
    localparam int AIP_HS_HZ   = 3_400_000;
    localparam int AIP_QW      = 8;
    // Quarter bit periods, rounded up so the rate never exceeds the limit
    localparam int AIP_Q_STD  = (AIP_CLK_HZ + 4 * AIP_STD_HZ - 1)
                              / (4 * AIP_STD_HZ);
    localparam int AIP_Q_FAST = (AIP_CLK_HZ + 4 * AIP_FAST_HZ - 1)
                              / (4 * AIP_FAST_HZ);
    localparam int AIP_Q_HS   = (AIP_CLK_HZ + 4 * AIP_HS_HZ - 1)
                              / (4 * AIP_HS_HZ);
    localparam logic [AIP_QW-1:0] AIP_QL_STD  = AIP_QW'(AIP_Q_STD);
    localparam logic [AIP_QW-1:0] AIP_QL_FAST = AIP_QW'(AIP_Q_FAST);
    localparam logic [AIP_QW-1:0] AIP_QL_HS   = AIP_QW'(AIP_Q_HS);

    // ------------------------------------------------------------
    // Bus codes
    // ------------------------------------------------------------
    localparam logic [4:0] AIP_ADDR_BASE = 5'h12;
    localparam logic [7:0] AIP_GC_ADDR   = 8'h00;
    localparam logic [7:0] AIP_GC_RESET  = 8'h06;
    localparam logic [3:0] AIP_ACK_BIT   = 4'h8;
    localparam logic [2:0] AIP_NB_WRITE  = 3'h4;
    localparam logic [2:0] AIP_NB_SHORT  = 3'h2;
    localparam logic [2:0] AIP_NB_RD2    = 3'h3;
    localparam logic [1:0] AIP_SYNC_RST  = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AIP_OP_WRITE  = 2'b00,
        AIP_OP_SETPTR = 2'b01,
        AIP_OP_READ   = 2'b10,
        AIP_OP_GCRST  = 2'b11
    } aip_op_t;

    typedef enum logic [1:0] {
        AIP_SPD_STD  = 2'b00,
        AIP_SPD_FAST = 2'b01,
        AIP_SPD_HS   = 2'b10
    } aip_spd_t;

    typedef enum logic [1:0] {
        AIP_STRAP_GND = 2'b00,
        AIP_STRAP_VDD = 2'b01,
        AIP_STRAP_SCL = 2'b10,
        AIP_STRAP_SDA = 2'b11
    } aip_strap_t;

    typedef enum logic [2:0] {
        AIP_ST_IDLE  = 3'b000,
        AIP_ST_START = 3'b001,
        AIP_ST_BIT   = 3'b010,
        AIP_ST_STOP  = 3'b011,
        AIP_ST_DONE  = 3'b100
    } aip_st_t;

    typedef struct packed {
        aip_op_t    op;
        aip_spd_t   spd;
        aip_strap_t strap;
        logic [1:0] ptr;
        logic       two;
        logic [15:0] wdata;
    } aip_cmd_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic        nack;
    } aip_rsp_t;

    typedef struct packed {
        aip_st_t           st;
        logic [AIP_QW-1:0] qcnt;
        logic [AIP_QW-1:0] qlen;
        logic [1:0]        ph;
        logic [3:0]        bitn;
        logic [2:0]        bidx;
        logic [2:0]        nbyt;
        logic [7:0]        sh;
        logic [15:0]       rdat;
        logic              nack;
        logic              scl_low;
        logic              sda_low;
        logic              rsp_v;
        aip_cmd_t          cmd;
    } aip_state_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] q;
    } aip_sync_t;

    localparam aip_state_t AIP_STATE_RST = '0;
    localparam aip_sync_t  AIP_SYNC_INIT = '{s1: AIP_SYNC_RST,
                                             s2: AIP_SYNC_RST,
                                             s3: AIP_SYNC_RST,
                                             q:  AIP_SYNC_RST};

endpackage : aip_pkg

// ==== hw/aip_sync.sv ====
`timescale 1ns/100ps
module aip_sync
    import aip_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Pins
    input  wire logic [1:0] i_pin,
    // Filtered levels
    output logic      [1:0] o_lvl
);

    aip_sync_t  r_reg;
    aip_sync_t  r_next;
    logic [1:0] agree;

    // ------------------------------------------------------------
    // Three stages, change taken once last two agree
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_agree
            // Disagreement keeps old level, so a slow edge counts once
            assign agree[g] = (r_reg.s2[g] == r_reg.s3[g]) ? r_reg.s3[g]
                                                          : r_reg.q[g];
        end
    endgenerate

    always_comb begin
        r_next    = r_reg;
        r_next.s1 = i_pin;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.q  = agree;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r_reg <= AIP_SYNC_INIT;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_lvl = r_reg.q;

endmodule : aip_sync

// ==== hw/aip_master.sv ====
`timescale 1ns/100ps
// Overview of operation
// - START: data falls while clock high
// - STOP: data rises while clock high
// - Data changes only while clock low
// - Start only when both lines high
// - Eight-bit bytes, ninth clock acknowledge
// - Receiver acknowledges by pulling data low
// - First byte: address then direction bit
// - Register words travel high byte first
// - Master ends read by not acknowledging
// - Pointer-only write just moves pointer
module aip_master
    import aip_pkg::*;
(
    // Clock and reset
    input  wire logic      i_clk,
    input  wire logic      i_rst_n,
    // Command
    input  wire logic      i_cmd_valid,
    input  wire aip_cmd_t  i_cmd,
    output logic           o_cmd_ready,
    // Response
    output logic           o_rsp_valid,
    output aip_rsp_t       o_rsp,
    output logic           o_busy,
    // Bus pins
    input  wire logic      i_scl,
    output logic           o_scl_o,
    output logic           o_scl_oe_n,
    input  wire logic      i_sda,
    output logic           o_sda_o,
    output logic           o_sda_oe_n
);

    aip_state_t r_reg;
    aip_state_t r_next;
    logic [1:0] lvl;
    logic       scl_s;
    logic       sda_s;
    logic       tick;
    logic       rx_byte;
    logic       last_byte;
    logic [7:0] cur_tx;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] tx_byte(input aip_cmd_t c,
                                           input logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            3'h0: begin
                if (c.op == AIP_OP_GCRST) begin
                    b = AIP_GC_ADDR;
                end else begin
                    b = {AIP_ADDR_BASE, c.strap,
                         c.op == AIP_OP_READ};
                end
            end
            3'h1: begin
                if (c.op == AIP_OP_GCRST) begin
                    b = AIP_GC_RESET;
                end else begin
                    b = {6'h00, c.ptr};
                end
            end
            3'h2: b = c.wdata[15:8];
            3'h3: b = c.wdata[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction : tx_byte

    function automatic logic [2:0] n_bytes(input aip_cmd_t c);
        logic [2:0] n;
        n = AIP_NB_SHORT;
        case (c.op)
            AIP_OP_WRITE:  n = AIP_NB_WRITE;
            AIP_OP_SETPTR: n = AIP_NB_SHORT;
            AIP_OP_READ:   n = c.two ? AIP_NB_RD2 : AIP_NB_SHORT;
            AIP_OP_GCRST:  n = AIP_NB_SHORT;
            default:       n = AIP_NB_SHORT;
        endcase
        return n;
    endfunction : n_bytes

    function automatic logic [AIP_QW-1:0] q_len(input aip_spd_t s);
        logic [AIP_QW-1:0] q;
        q = AIP_QL_STD;
        case (s)
            AIP_SPD_STD:  q = AIP_QL_STD;
            AIP_SPD_FAST: q = AIP_QL_FAST;
            AIP_SPD_HS:   q = AIP_QL_HS;
            default:      q = AIP_QL_HS;
        endcase
        return q;
    endfunction : q_len

    // ------------------------------------------------------------
    // Pin filter
    // ------------------------------------------------------------
    aip_sync u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pin   ({i_scl, i_sda}),
        .o_lvl   (lvl)
    );
    assign scl_s = lvl[1];
    assign sda_s = lvl[0];

    assign tick      = (r_reg.qcnt == '0);
    assign rx_byte   = (r_reg.cmd.op == AIP_OP_READ) && (r_reg.bidx != 3'h0);
    assign last_byte = ((r_reg.bidx + 3'h1) == r_reg.nbyt);
    assign cur_tx    = tx_byte(r_reg.cmd, r_reg.bidx);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        r_next       = r_reg;
        r_next.rsp_v = 1'b0;
        if (r_reg.st != AIP_ST_IDLE) begin
            r_next.qcnt = tick ? r_reg.qlen - 1'b1 : r_reg.qcnt - 1'b1;
        end
        case (r_reg.st)
            AIP_ST_IDLE: begin
                if (i_cmd_valid) begin
                    r_next.cmd     = i_cmd;
                    r_next.st      = AIP_ST_START;
                    r_next.ph      = 2'd0;
                    r_next.qlen    = q_len(i_cmd.spd);
                    r_next.qcnt    = q_len(i_cmd.spd) - 1'b1;
                    r_next.nbyt    = n_bytes(i_cmd);
                    r_next.bidx    = 3'h0;
                    r_next.rdat    = 16'h0000;
                    r_next.nack    = 1'b0;
                    r_next.scl_low = 1'b0;
                    r_next.sda_low = 1'b0;
                end
            end
            AIP_ST_START: begin
                if (r_reg.ph == 2'd0 && !(scl_s && sda_s)) begin
                    r_next.qcnt = r_reg.qlen - 1'b1;
                end else if (tick) begin
                    case (r_reg.ph)
                        2'd0: begin
                            r_next.sda_low = 1'b1;
                            r_next.ph      = 2'd1;
                        end
                        2'd1: r_next.ph = 2'd2;
                        default: begin
                            r_next.scl_low = 1'b1;
                            r_next.st      = AIP_ST_BIT;
                            r_next.ph      = 2'd0;
                            r_next.bitn    = 4'h0;
                            r_next.sh      = tx_byte(r_reg.cmd, 3'h0);
                        end
                    endcase
                end
            end
            AIP_ST_BIT: begin
                if (tick) begin
                    r_next.ph = r_reg.ph + 2'd1;
                    case (r_reg.ph)
                        2'd0: begin
                            // Data moves a full quarter after clock fell
                            if (r_reg.bitn == AIP_ACK_BIT) begin
                                r_next.sda_low = rx_byte && !last_byte;
                            end else begin
                                r_next.sda_low = !rx_byte && !r_reg.sh[7];
                            end
                        end
                        2'd1: r_next.scl_low = 1'b0;
                        2'd2: r_next.scl_low = 1'b0;
                        default: begin
                            r_next.scl_low = 1'b1;
                            if (r_reg.bitn != AIP_ACK_BIT) begin
                                r_next.sh   = {r_reg.sh[6:0], sda_s};
                                r_next.bitn = r_reg.bitn + 4'h1;
                            end else if (!rx_byte && sda_s) begin
                                r_next.nack = 1'b1;
                                r_next.st   = AIP_ST_STOP;
                                r_next.ph   = 2'd0;
                            end else begin
                                if (rx_byte) begin
                                    r_next.rdat = {r_reg.rdat[7:0], r_reg.sh};
                                end
                                r_next.bidx = r_reg.bidx + 3'h1;
                                r_next.bitn = 4'h0;
                                r_next.sh   = tx_byte(r_reg.cmd,
                                                      r_reg.bidx + 3'h1);
                                if (last_byte) begin
                                    r_next.st = AIP_ST_STOP;
                                    r_next.ph = 2'd0;
                                end
                            end
                        end
                    endcase
                end
            end
            AIP_ST_STOP: begin
                if (tick) begin
                    r_next.ph = r_reg.ph + 2'd1;
                    case (r_reg.ph)
                        2'd0: r_next.sda_low = 1'b1;
                        2'd1: r_next.scl_low = 1'b0;
                        2'd2: r_next.sda_low = 1'b0;
                        default: r_next.st = AIP_ST_DONE;
                    endcase
                end
            end
            AIP_ST_DONE: begin
                r_next.rsp_v = 1'b1;
                r_next.st    = AIP_ST_IDLE;
            end
            default: r_next = AIP_STATE_RST;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r_reg <= AIP_STATE_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain both lines; device never holds clock so no stretching
    assign o_scl_o     = 1'b0;
    assign o_scl_oe_n  = !r_reg.scl_low;
    assign o_sda_o     = 1'b0;
    assign o_sda_oe_n  = !r_reg.sda_low;
    assign o_cmd_ready = (r_reg.st == AIP_ST_IDLE);
    assign o_busy      = (r_reg.st != AIP_ST_IDLE);
    assign o_rsp_valid = r_reg.rsp_v;
    assign o_rsp       = '{rdata: r_reg.rdat, nack: r_reg.nack};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_start_fall: assert property (
        ($rose(r_reg.sda_low) && r_reg.st == AIP_ST_START)
        |-> !r_reg.scl_low && !$past(r_reg.scl_low))
        else $error("start not made with clock high");

    chk_stop_rise: assert property (
        ($fell(r_reg.sda_low) && r_reg.st == AIP_ST_STOP)
        |-> !r_reg.scl_low ##[1:260] r_reg.st == AIP_ST_DONE)
        else $error("stop not made with clock high");

    chk_data_stable: assert property (
        (r_reg.st == AIP_ST_BIT && $changed(r_reg.sda_low))
        |-> r_reg.scl_low && $past(r_reg.scl_low))
        else $error("data moved while clock high");

    chk_wait_idle: assert property (
        (r_reg.st == AIP_ST_START && r_reg.ph == 2'd0 && !(scl_s && sda_s))
        |=> r_reg.st == AIP_ST_START && r_reg.ph == 2'd0 && !r_reg.sda_low)
        else $error("start issued on busy bus");

    chk_ack_release: assert property (
        (r_reg.st == AIP_ST_BIT && r_reg.bitn == AIP_ACK_BIT
         && r_reg.ph != 2'd0 && !rx_byte) |-> !r_reg.sda_low)
        else $error("data held during device acknowledge");

    chk_master_ack: assert property (
        (r_reg.st == AIP_ST_BIT && r_reg.bitn == AIP_ACK_BIT
         && r_reg.ph != 2'd0 && rx_byte) |-> r_reg.sda_low == !last_byte)
        else $error("wrong master acknowledge");

    chk_tx_bits: assert property (
        (r_reg.st == AIP_ST_BIT && !rx_byte && r_reg.bitn < AIP_ACK_BIT
         && r_reg.ph != 2'd0)
        |-> r_reg.sda_low == !cur_tx[3'(4'h7 - r_reg.bitn)])
        else $error("transmitted bit mismatch");

    chk_byte_count: assert property (
        $rose(o_busy) |-> r_reg.bidx == 3'h0 && r_reg.nbyt ==
            ((r_reg.cmd.op == AIP_OP_WRITE) ? 3'h4 :
             (r_reg.cmd.op == AIP_OP_READ && r_reg.cmd.two) ? 3'h3 : 3'h2))
        else $error("wrong byte count for command");

    chk_rsp_after_stop: assert property (
        r_reg.rsp_v |-> $past(r_reg.st) == AIP_ST_DONE
        && !r_reg.scl_low && !r_reg.sda_low)
        else $error("response without released bus");

    cov_write: cover property (r_reg.rsp_v && !r_reg.nack
                               && r_reg.cmd.op == AIP_OP_WRITE);
    cov_read2: cover property (r_reg.rsp_v && !r_reg.nack
                               && r_reg.cmd.op == AIP_OP_READ
                               && r_reg.cmd.two);
    cov_gcall: cover property (r_reg.rsp_v && r_reg.cmd.op == AIP_OP_GCRST);
    cov_nack:  cover property (r_reg.rsp_v && r_reg.nack);

endmodule : aip_master

// ==== bench/aip_slave_model.sv ====
`timescale 1ns/100ps
module aip_slave_model
    import aip_pkg::*;
#(
    parameter logic [1:0]  STRAP  = 2'h0,
    parameter logic [15:0] HI_RST = 16'hFFFF
)(
    // Bus pins, clock is input only
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_oe_n
);
    // ----------------------------------------
    // Register file and bus state
    // ----------------------------------------
    logic [15:0] regs [4];
    logic [15:0] word;
    logic [7:0]  sh;
    logic [7:0]  hi;
    logic [1:0]  ptr;
    logic        act;
    logic        rd;
    logic        gc;
    logic        tx;
    int          nbit;
    int          nbyt;

    task automatic rst_regs;
        regs[0] = 16'h0000;
        regs[1] = 16'h8583;
        regs[2] = 16'h8000;
        regs[3] = HI_RST;
    endtask : rst_regs

    task automatic got_byte;
        logic ack;
        ack = 1'b1;
        if (nbyt == 0) begin
            if (sh[7:1] == {5'h12, STRAP}) rd = sh[0];
            else if (sh == 8'h00) gc = 1'b1;
            else begin
                ack = 1'b0;
                act = 1'b0;
            end
        end else if (gc) begin
            if (sh == 8'h06) rst_regs();
        end else if (nbyt == 1) ptr = sh[1:0];
        else if (nbyt == 2) hi = sh;
        else if (nbyt == 3) regs[ptr] = {hi, sh};
        if (ack) o_sda_oe_n <= #5 1'b0;
    endtask : got_byte

    initial begin
        rst_regs();
        ptr        = 2'h0;
        act        = 1'b0;
        tx         = 1'b0;
        o_sda_oe_n = 1'b1;
    end

    // ----------------------------------------
    // Control conditions
    // ----------------------------------------
    always @(negedge i_sda) if (i_scl === 1'b1) begin
        act  = 1'b1;
        nbit = -1;
        nbyt = 0;
        rd   = 1'b0;
        gc   = 1'b0;
        tx   = 1'b0;
        o_sda_oe_n <= #5 1'b1;
    end

    always @(posedge i_sda) if (i_scl === 1'b1) begin
        act = 1'b0;
        tx  = 1'b0;
        o_sda_oe_n <= #5 1'b1;
    end

    // ----------------------------------------
    // Bit engine, drives only while clock low
    // ----------------------------------------
    always @(posedge i_scl) if (act) begin
        if (nbit < 8) sh = {sh[6:0], i_sda};
        else if (tx && i_sda) tx = 1'b0;
    end

    always @(negedge i_scl) if (act) begin
        nbit = nbit + 1;
        if (nbit == 8) begin
            if (tx) o_sda_oe_n <= #5 1'b1;
            else if (!rd || nbyt == 0) got_byte();
        end else if (nbit == 9) begin
            nbit = 0;
            nbyt = nbyt + 1;
            o_sda_oe_n <= #5 1'b1;
            if (rd && nbyt == 1) begin
                tx   = 1'b1;
                word = regs[ptr];
            end else if (tx) word = {word[7:0], 8'hFF};
            else if (rd) act = 1'b0;
        end
        if (tx && nbit >= 0 && nbit < 8) o_sda_oe_n <= #5 word[15 - nbit];
    end
endmodule : aip_slave_model

// ==== bench/aip_master_test.sv ====
`timescale 1ns/100ps
module aip_master_test;
    import aip_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int LIMIT = 60000;
    logic        i_clk;
    logic        i_rst_n;
    logic        i_cmd_valid;
    aip_cmd_t    i_cmd;
    logic        o_cmd_ready;
    logic        o_rsp_valid;
    aip_rsp_t    o_rsp;
    logic        o_busy;
    logic        o_scl_o;
    logic        o_scl_oe_n;
    logic        o_sda_o;
    logic        o_sda_oe_n;
    logic [2:0]  slv_oe_n;
    logic        hold_n;
    wire logic   scl_w;
    wire logic   sda_w;
    int          errors;
    int          n_compared;
    int          cycles;
    int          nstart;
    int          nstop;

    // Pulled-up wires
    // Bench may hold clock low like a slow peer, to make the bus busy
    assign scl_w = !((!o_scl_oe_n && !o_scl_o) || !hold_n);
    assign sda_w = !((!o_sda_oe_n && !o_sda_o) || !(&slv_oe_n));

    aip_master aip_master_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
        .o_rsp(o_rsp), .o_busy(o_busy), .i_scl(scl_w), .o_scl_o(o_scl_o),
        .o_scl_oe_n(o_scl_oe_n), .i_sda(sda_w), .o_sda_o(o_sda_o),
        .o_sda_oe_n(o_sda_oe_n));

    // Strap 3 left empty so that address is never answered
    for (genvar g = 0; g < 3; g++) begin : g_dev
        aip_slave_model #(.STRAP(2'(g)), .HI_RST(16'hFFFF)) aip_slave_model_i (
            .i_scl(scl_w), .i_sda(sda_w), .o_sda_oe_n(slv_oe_n[g]));
    end

    always @(negedge sda_w) if (scl_w === 1'b1) nstart++;
    always @(posedge sda_w) if (scl_w === 1'b1) nstop++;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic run(input aip_op_t op, input int spd, input int strap,
                       input logic [1:0] ptr, input logic two,
                       input logic [15:0] wd, input logic [16:0] exp);
        int n;
        int s0;
        int p0;
        s0 = nstart;
        p0 = nstop;
        i_cmd = '{op: op, spd: aip_spd_t'(spd), strap: aip_strap_t'(strap),
                  ptr: ptr, two: two, wdata: wd};
        i_cmd_valid = 1'b1;
        check(17'(o_cmd_ready), 17'h1);
        @(posedge i_clk); #1;
        i_cmd_valid = 1'b0;
        check(17'({o_cmd_ready, o_busy}), 17'h1);
        n = 0;
        while (o_rsp_valid !== 1'b1 && n < 20000) begin
            @(posedge i_clk); #1;
            n++;
        end
        if (n == 20000) errors++;
        check(o_rsp, exp);
        check(17'(nstart - s0), 17'h1);
        check(17'(nstop - p0), 17'h1);
        @(posedge i_clk); #1;
    endtask : run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        check(17'({o_scl_oe_n, o_sda_oe_n, o_cmd_ready, o_rsp_valid,
                   o_busy}), 17'h1C);
        check(o_rsp, 17'h0);
    endtask : t_reset

    task automatic t_busy;
        hold_n = 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        fork
            begin
                repeat (40) @(posedge i_clk);
                #1;
                check(17'({o_scl_oe_n, o_sda_oe_n, o_busy}), 17'h7);
                hold_n = 1'b1;
            end
            run(AIP_OP_READ, 3, 2, 2'h0, 1'b1, 16'h0, 17'h1FFFE);
        join
    endtask : t_busy

    task automatic t_write_read;
        for (int s = 0; s < 3; s++)
            run(AIP_OP_WRITE, s, s, 2'h2, 1'b0, 16'hA5C0 + 16'(s), 17'h0);
        for (int s = 0; s < 3; s++)
            run(AIP_OP_READ, s, s, 2'h0, 1'b1, 16'h0,
                {16'hA5C0 + 16'(s), 1'b0});
    endtask : t_write_read

    task automatic t_unmatched;
        run(AIP_OP_WRITE, 1, 3, 2'h1, 1'b0, 16'h1111, 17'h1);
        run(AIP_OP_READ, 2, 3, 2'h0, 1'b1, 16'h0, 17'h1);
    endtask : t_unmatched

    task automatic t_pointer;
        logic [15:0] tbl [4];
        tbl = '{16'h0000, 16'h8583, 16'hA5C2, 16'hFFFF};
        for (int p = 0; p < 4; p++) begin
            run(AIP_OP_SETPTR, 2, 2, 2'(p), 1'b0, 16'h0, 17'h0);
            run(AIP_OP_READ, 2, 2, 2'h0, 1'b1, 16'h0, {tbl[p], 1'b0});
        end
        run(AIP_OP_READ, 2, 2, 2'h0, 1'b0, 16'h0, {8'h0, 8'hFF, 1'b0});
        run(AIP_OP_READ, 2, 2, 2'h0, 1'b1, 16'h0, 17'h1FFFE);
    endtask : t_pointer

    task automatic t_gc_reset;
        run(AIP_OP_WRITE, 2, 1, 2'h1, 1'b0, 16'h1234, 17'h0);
        run(AIP_OP_READ, 2, 1, 2'h0, 1'b1, 16'h0, 17'h02468);
        run(AIP_OP_GCRST, 2, 0, 2'h0, 1'b0, 16'h0, 17'h0);
        run(AIP_OP_READ, 2, 1, 2'h0, 1'b1, 16'h0, 17'h10B06);
        run(AIP_OP_READ, 2, 0, 2'h0, 1'b1, 16'h0, 17'h10000);
    endtask : t_gc_reset

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    initial begin
        cycles = 0;
        forever begin
            @(posedge i_clk);
            cycles++;
            if (cycles == LIMIT) begin
                errors++;
                close_out();
            end
        end
    end

    initial begin
        errors      = 0;
        n_compared  = 0;
        nstart      = 0;
        nstop       = 0;
        i_rst_n     = 1'b0;
        i_cmd_valid = 1'b0;
        i_cmd       = '0;
        hold_n      = 1'b1;
        repeat (5) @(posedge i_clk);
        #1;
        t_reset();
        i_rst_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        t_reset();
        t_write_read();
        t_unmatched();
        t_pointer();
        t_busy();
        t_gc_reset();
        close_out();
    end
endmodule : aip_master_test
